// ===== src/iob_params.svh
`ifndef IOB_PARAMS_SVH
`define IOB_PARAMS_SVH

// ----------------------------------------
// Clock and bus timing
// ----------------------------------------
`define IOB_CLK_NS 20
`define IOB_CEIL(ns) (((ns) + `IOB_CLK_NS - 1) / `IOB_CLK_NS)
`define IOB_T_IND_NS 400
`define IOB_T_TEST_NS 2900
`define IOB_T_STRB_NS 3100
`define IOB_STRB_LEN_NS 800
`define IOB_T_END_NS 5200
`define IOB_STALL_MIN_NS 500
`define IOB_IND_CYC `IOB_CEIL(`IOB_T_IND_NS)
`define IOB_TEST_CYC `IOB_CEIL(`IOB_T_TEST_NS)
`define IOB_STRB_CYC `IOB_CEIL(`IOB_T_STRB_NS)
`define IOB_STRB_LEN_CYC `IOB_CEIL(`IOB_STRB_LEN_NS)
`define IOB_END_CYC `IOB_CEIL(`IOB_T_END_NS)

// ----------------------------------------
// Widths, sizes and reset values
// ----------------------------------------
`define IOB_DW 12
`define IOB_AW 6
`define IOB_FIFO_DEPTH 16
`define IOB_LOAD_ADDR 6'h01
`define IOB_ACC_RST 12'h000
`endif

// ===== src/iob_pkg.sv
package iob_pkg;
  // Command codes on the core-side request port
  typedef enum logic [2:0] {
    IOB_OP_CTRL = 3'h0,
    IOB_OP_OUT = 3'h1,
    IOB_OP_IN = 3'h2,
    IOB_OP_SKIP = 3'h3,
    IOB_OP_MASK = 3'h4,
    IOB_OP_STALL = 3'h5
  } iob_op_type;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    IOB_IDLE = 4'h1,
    IOB_RUN = 4'h2,
    IOB_WAIT = 4'h4,
    IOB_DONE = 4'h8
  } iob_state_type;
endpackage

// ===== src/iob_fifo.sv
`include "iob_params.svh"
module iob_fifo #(
  parameter int Width = `IOB_DW + 2,
  parameter int Depth = `IOB_FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [Width-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [Width-1:0] outData
);
  localparam int PtrW = $clog2(Depth);

  // ----------------------------------------
  // Elaboration check
  // ----------------------------------------
  if (Depth < 2 || (1 << PtrW) != Depth || Width < 1) begin : gBad
    $error("iob_fifo: depth must be a power of two");
  end

  logic [Width-1:0] mem_q [Depth]; // Storage, no reset needed
  logic [PtrW-1:0] wrPtr_q; // Next slot to fill
  logic [PtrW-1:0] rdPtr_q; // Next slot to drain
  logic [PtrW:0] count_q; // Words held in storage
  logic outValid_q; // Output register holds a word
  logic [Width-1:0] outData_q; // Registered read data
  logic push;
  logic pop;

  // Full counts the output register too, so Depth words at most
  assign inReady =
    (count_q + (PtrW + 1)'(outValid_q)) != (PtrW + 1)'(Depth);
  assign push = inValid && inReady;
  assign pop = (count_q != '0) && (!outValid_q || outReady);
  assign outValid = outValid_q;
  assign outData = outData_q;

  // Storage write
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wrPtr_q] <= inData;
    end
  end

  // Pointers and fill level
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
      case ({push, pop})
        2'b10: count_q <= count_q + 1'b1;
        2'b01: count_q <= count_q - 1'b1;
        default: count_q <= count_q;
      endcase
    end
  end

  // Read data register, drained by the consumer
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      outValid_q <= 1'b0;
      outData_q <= '0;
    end else if (pop) begin
      outValid_q <= 1'b1;
      outData_q <= mem_q[rdPtr_q];
    end else if (outReady) begin
      outValid_q <= 1'b0;
    end
  end
endmodule

// ===== src/iob_bus_ctrl.sv
`include "iob_params.svh"
module iob_bus_ctrl
  import iob_pkg::*;
#(
  parameter int DataW = `IOB_DW,
  parameter int FifoDepth = `IOB_FIFO_DEPTH,
  parameter logic [`IOB_AW-1:0] LoadAddr = `IOB_LOAD_ADDR
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  // Core-side command port
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic [2:0] cmdOp,
  input wire logic [`IOB_AW-1:0] cmdAddr,
  input wire logic [DataW-1:0] cmdAcc,
  // Hardware load request and its bus indication
  input wire logic loadReq,
  output logic loadActive_n,
  // Result stream through the FIFO
  output logic resValid,
  input wire logic resReady,
  output logic [DataW-1:0] resData,
  output logic resSkip,
  output logic resLoad,
  output logic busy,
  // Party-line bus pins, active low except ioDataOe
  input wire logic [DataW-1:0] ioDataIn_n,
  output logic [DataW-1:0] ioDataOut_n,
  output logic ioDataOe,
  output logic [`IOB_AW-1:0] ioAddr_n,
  output logic outXferInd_n,
  output logic inXferInd_n,
  output logic ctrlPulseInd_n,
  output logic skipTestInd_n,
  output logic setMaskInd_n,
  output logic xferStrobe_n,
  input wire logic readyTest_n,
  input wire logic stallIn_n
);
  // ----------------------------------------
  // Timing points within one bus instruction
  // ----------------------------------------
  localparam int PhW = $clog2(`IOB_END_CYC + 1);
  localparam logic [PhW-1:0] IndC = PhW'(`IOB_IND_CYC);
  localparam logic [PhW-1:0] TestC = PhW'(`IOB_TEST_CYC);
  localparam logic [PhW-1:0] StrbC = PhW'(`IOB_STRB_CYC);
  localparam logic [PhW-1:0] StrbE =
    PhW'(`IOB_STRB_CYC + `IOB_STRB_LEN_CYC);
  localparam logic [PhW-1:0] EndC = PhW'(`IOB_END_CYC - 1);
  localparam int ResW = DataW + 2;

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (DataW < 1 || DataW > `IOB_DW) begin : gBadW
    $error("iob_bus_ctrl: data width out of range");
  end
  if (`IOB_STRB_CYC + `IOB_STRB_LEN_CYC > `IOB_END_CYC) begin : gBadT
    $error("iob_bus_ctrl: strobe runs past instruction end");
  end
  if (`IOB_TEST_CYC >= `IOB_STRB_CYC) begin : gBadS
    $error("iob_bus_ctrl: ready test must precede strobe");
  end

  // True when the command tests a peripheral ready response
  function automatic logic isTested(input iob_op_type op);
    return op == IOB_OP_OUT || op == IOB_OP_IN || op == IOB_OP_SKIP;
  endfunction

  // True when the command drives the accumulator outward
  function automatic logic isOutward(input iob_op_type op);
    return op == IOB_OP_CTRL || op == IOB_OP_MASK || op == IOB_OP_OUT;
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [DataW-1:0] dataMeta_q; // First stage, read by second only
  logic [DataW-1:0] dataSync_q; // Settled data lines
  logic rdyMeta_q;
  logic rdySync_q; // Settled ready test, low is asserted
  logic stlMeta_q;
  logic stlSync_q; // Settled stall input, low is asserted

  // Two flops on every input arriving from the cable
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dataMeta_q <= '1;
      dataSync_q <= '1;
      rdyMeta_q <= 1'b1;
      rdySync_q <= 1'b1;
      stlMeta_q <= 1'b1;
      stlSync_q <= 1'b1;
    end else begin
      dataMeta_q <= ioDataIn_n;
      dataSync_q <= dataMeta_q;
      rdyMeta_q <= readyTest_n;
      rdySync_q <= rdyMeta_q;
      stlMeta_q <= stallIn_n;
      stlSync_q <= stlMeta_q;
    end
  end

  // ----------------------------------------
  // Sequencer state
  // ----------------------------------------
  iob_state_type state_q; // Sequencer state
  iob_op_type op_q; // Command in progress
  logic [`IOB_AW-1:0] addr_q; // Instruction address field
  logic [DataW-1:0] acc_q; // Working accumulator copy
  logic loadMode_q; // Current cycle is a load transfer
  logic testHit_q; // Peripheral answered ready
  logic [PhW-1:0] phase_q; // Cycle within the instruction
  logic fifoInReady;
  logic fifoInValid;
  logic start;
  logic startLoad;
  logic indWin;
  logic strbWin;
  logic strbOn;

  // Load requests take priority over program commands
  assign startLoad = state_q == IOB_IDLE && loadReq && fifoInReady;
  // Start only with FIFO space, so back-pressure halts commands
  assign cmdReady = state_q == IOB_IDLE && !loadReq && fifoInReady;
  assign start = startLoad || (cmdValid && cmdReady);
  assign busy = state_q != IOB_IDLE;
  assign fifoInValid = state_q == IOB_DONE;

  // Instruction windows decoded from the phase count
  assign indWin = state_q == IOB_RUN && phase_q >= IndC;
  assign strbWin = state_q == IOB_RUN && phase_q >= StrbC &&
    phase_q < StrbE;
  // Strobe is unconditional for control and mask only
  assign strbOn = strbWin && (!isTested(op_q) || testHit_q);

  // State transitions
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q <= IOB_IDLE;
    end else begin
      case (state_q)
        IOB_IDLE: begin
          if (startLoad) begin
            state_q <= IOB_RUN;
          end else if (start) begin
            case (iob_op_type'(cmdOp))
              IOB_OP_STALL: state_q <= IOB_WAIT;
              IOB_OP_CTRL, IOB_OP_OUT, IOB_OP_IN,
              IOB_OP_SKIP, IOB_OP_MASK: state_q <= IOB_RUN;
              // Unknown code: finish at once, no bus activity
              default: state_q <= IOB_DONE;
            endcase
          end
        end
        IOB_RUN: begin
          // Fixed length for every bus command
          if (phase_q == EndC) begin
            state_q <= IOB_DONE;
          end
        end
        IOB_WAIT: begin
          // Already-low stall line means no stop at all
          if (!stlSync_q) begin
            state_q <= IOB_DONE;
          end
        end
        IOB_DONE: begin
          if (fifoInReady) begin
            state_q <= IOB_IDLE;
          end
        end
        default: state_q <= IOB_IDLE;
      endcase
    end
  end

  // Phase counter within the instruction
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      phase_q <= '0;
    end else if (state_q == IOB_RUN) begin
      phase_q <= phase_q + 1'b1;
    end else begin
      phase_q <= '0;
    end
  end

  // Command capture
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      op_q <= IOB_OP_CTRL;
      addr_q <= '0;
      loadMode_q <= 1'b0;
    end else if (startLoad) begin
      // Load transfers are always inward
      op_q <= IOB_OP_IN;
      addr_q <= LoadAddr;
      loadMode_q <= 1'b1;
    end else if (start) begin
      op_q <= iob_op_type'(cmdOp);
      addr_q <= cmdAddr;
      loadMode_q <= 1'b0;
    end
  end

  // Ready test sampled once, late enough for slow peripherals
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      testHit_q <= 1'b0;
    end else if (start) begin
      testHit_q <= 1'b0;
    end else if (state_q == IOB_RUN && phase_q == TestC &&
                 isTested(op_q)) begin
      testHit_q <= !rdySync_q;
    end
  end

  // Accumulator copy: outward value or inward capture
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      acc_q <= DataW'(`IOB_ACC_RST);
    end else if (start) begin
      // Input clears first, whether ready or not
      if (startLoad || iob_op_type'(cmdOp) == IOB_OP_IN) begin
        acc_q <= DataW'(`IOB_ACC_RST);
      end else begin
        acc_q <= cmdAcc;
      end
    end else if (state_q == IOB_RUN && op_q == IOB_OP_IN &&
                 testHit_q && phase_q == StrbE - 1'b1) begin
      // Low line means a one in that bit
      acc_q <= ~dataSync_q;
    end
  end

  // ----------------------------------------
  // Bus pin drivers, all registered
  // ----------------------------------------

  // Address and data lines, inverted since low is asserted
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ioAddr_n <= '1;
      ioDataOut_n <= '1;
      ioDataOe <= 1'b0;
    end else if (state_q == IOB_RUN) begin
      // Line one carries instruction bit one
      ioAddr_n <= ~addr_q;
      ioDataOut_n <= ~acc_q;
      // Unready output drives but never strobes: no transfer
      ioDataOe <= isOutward(op_q);
    end else begin
      // Released between instructions for the peripherals
      ioAddr_n <= '1;
      ioDataOut_n <= '1;
      ioDataOe <= 1'b0;
    end
  end

  // Instruction indicator lines, one per instruction type
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      outXferInd_n <= 1'b1;
      inXferInd_n <= 1'b1;
      ctrlPulseInd_n <= 1'b1;
      skipTestInd_n <= 1'b1;
      setMaskInd_n <= 1'b1;
    end else begin
      outXferInd_n <= !(indWin && op_q == IOB_OP_OUT);
      inXferInd_n <= !(indWin && op_q == IOB_OP_IN);
      skipTestInd_n <= !(indWin && op_q == IOB_OP_SKIP);
      // Mask command pulses the control line with the strobe
      ctrlPulseInd_n <= !((indWin && op_q == IOB_OP_CTRL) ||
        (strbWin && op_q == IOB_OP_MASK));
      setMaskInd_n <= !(indWin && op_q == IOB_OP_MASK);
    end
  end

  // Strobe and load indication
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      xferStrobe_n <= 1'b1;
      loadActive_n <= 1'b1;
    end else begin
      xferStrobe_n <= !strbOn;
      // Held through the whole load cycle
      loadActive_n <= !(loadMode_q && state_q != IOB_IDLE);
    end
  end

  // ----------------------------------------
  // Result FIFO
  // ----------------------------------------
  logic [ResW-1:0] fifoOut;
  logic resultSkip;

  // Skip only for a tested command whose peripheral answered
  assign resultSkip = isTested(op_q) && testHit_q;

  // Results queue up; a slow consumer stalls new commands
  iob_fifo #(
    .Width(ResW),
    .Depth(FifoDepth)
  ) uFifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData({loadMode_q, resultSkip, acc_q}),
    .outValid(resValid),
    .outReady(resReady),
    .outData(fifoOut)
  );

  assign resData = fifoOut[DataW-1:0];
  assign resSkip = fifoOut[DataW];
  assign resLoad = fifoOut[DataW+1];
endmodule

// ===== sim/iob_bus_ctrl_checker.sv
`include "iob_params.svh"
module iob_bus_ctrl_checker
  import iob_pkg::*;
#(parameter int DataW = `IOB_DW) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cmdValid,
  input wire logic cmdReady,
  input wire logic [2:0] cmdOp,
  input wire logic [`IOB_AW-1:0] cmdAddr,
  input wire logic [DataW-1:0] cmdAcc,
  input wire logic loadReq,
  input wire logic busy,
  input wire logic [DataW-1:0] ioDataOut_n,
  input wire logic ioDataOe,
  input wire logic [`IOB_AW-1:0] ioAddr_n,
  input wire logic outXferInd_n,
  input wire logic inXferInd_n,
  input wire logic skipTestInd_n,
  input wire logic xferStrobe_n,
  input wire logic readyTest_n,
  input wire logic stallIn_n
);
  // ----------------
  // Helpers
  // ----------------
  logic take, busOp, rdySeen_q, stlSeen_q;
  logic [3:0] op_q; // Eight marks a load cycle
  int len_q, ref_q;
  assign take = cmdValid && cmdReady;
  assign busOp = op_q < 4'h5 || op_q == 4'h8;
  // Kind of the cycle in flight
  always_ff @(posedge ref_clk) begin
    if (!rst_n) op_q <= 4'hf;
    else if (take) op_q <= {1'b0, cmdOp};
    else if (!busy && loadReq) op_q <= 4'h8;
  end
  // Sticky sightings, restarted per command
  always_ff @(posedge ref_clk) begin
    rdySeen_q <= (take ? 1'b0 : rdySeen_q) | ~readyTest_n;
    stlSeen_q <= (take ? 1'b0 : stlSeen_q) | ~stallIn_n;
  end
  // Busy length; first bus cycle is the yardstick
  always_ff @(posedge ref_clk) begin
    len_q <= (busy && rst_n) ? len_q + 1 : 0;
    if (!rst_n) ref_q <= 0;
    else if (!busy && len_q != 0 && busOp && ref_q == 0) ref_q <= len_q;
  end
  // ----------------
  // Properties
  // ----------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  AST_ADDR: assert property (take && cmdOp < 3'h5 |->
    ##3 ioAddr_n == ~$past(cmdAddr, 3)) else $error("address lines wrong");
  AST_OUT_DATA: assert property (take && cmdOp inside {0, 1, 4} |->
    ##3 ioDataOe && ioDataOut_n == ~$past(cmdAcc, 3))
    else $error("data lines not the accumulator");
  AST_IDLE: assert property (!busy && !$past(busy) |->
    &ioAddr_n && xferStrobe_n && !ioDataOe) else $error("bus not released");
  AST_CTRL_STB: assert property (take && cmdOp inside {0, 4} |->
    ##[150:200] !xferStrobe_n) else $error("no strobe on control");
  AST_TEST_STB: assert property (!xferStrobe_n &&
    op_q inside {4'h1, 4'h2, 4'h3} |-> rdySeen_q)
    else $error("strobe without ready");
  AST_IND_OUT: assert property (take && cmdOp == 3'h1 |->
    outXferInd_n [*8] ##[5:25] (!outXferInd_n && inXferInd_n && skipTestInd_n))
    else $error("output indicator wrong");
  AST_LEN: assert property ($fell(busy) && busOp && ref_q != 0 |->
    len_q == ref_q) else $error("instruction length differs");
  AST_STALL: assert property ($fell(busy) && op_q == 4'h5 |->
    stlSeen_q) else $error("stall ended without input");
endmodule

// ===== sim/iob_periph_model.sv
module iob_periph_model #(
  parameter logic [5:0] MyAddr = 6'h01,
  parameter int MaskBit = 3
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic rdy,
  input wire logic [11:0] rdData,
  input wire logic stallGo,
  input wire logic [5:0] ioAddr_n,
  input wire logic [11:0] busData_n,
  input wire logic outXferInd_n,
  input wire logic inXferInd_n,
  input wire logic skipTestInd_n,
  input wire logic ctrlPulseInd_n,
  input wire logic setMaskInd_n,
  input wire logic xferStrobe_n,
  input wire logic loadActive_n,
  output logic [11:0] drvData_n,
  output logic readyTest_n,
  output logic stallIn_n,
  output logic [11:0] gotData,
  output logic maskQ,
  output logic intReq_n,
  output int ctrlCnt
);
  logic hit, tested, stb, pend_q;
  int stall_cmd; // Stall pulse cycles left
  assign hit = ioAddr_n == ~MyAddr;
  assign tested = !(outXferInd_n && inXferInd_n && skipTestInd_n &&
    loadActive_n);
  assign stb = hit && !xferStrobe_n;
  // Answer lines; released data floats up to the idle level
  always_ff @(posedge ref_clk) begin
    readyTest_n <= !(hit && rdy && tested);
    drvData_n <= (hit && rdy && !(inXferInd_n && loadActive_n))
      ? ~rdData : 12'hfff;
  end
  // Actions timed by the strobe
  always_ff @(posedge ref_clk) begin
    if (!rst_n) ctrlCnt <= 0;
    else if (stb && !ctrlPulseInd_n && setMaskInd_n)
      ctrlCnt <= ctrlCnt + 1;
    if (!rst_n) gotData <= 12'h000;
    else if (stb && !outXferInd_n) gotData <= ~busData_n;
    if (!setMaskInd_n && !xferStrobe_n && ioAddr_n[0])
      maskQ <= ~busData_n[MaskBit];
  end
  // Request latched while ready, dropped by an addressed strobe
  always_ff @(posedge ref_clk) begin
    if (!rst_n || stb) pend_q <= 1'b0;
    else if (rdy) pend_q <= 1'b1;
  end
  // Only an unmasked peripheral may request
  assign intReq_n = !(pend_q && maskQ);
  // 600 ns pulse, safely past the 500 ns floor
  always_ff @(posedge ref_clk) begin
    stall_cmd <= !rst_n ? 0 : stallGo ? 30 : stall_cmd > 0 ? stall_cmd - 1 : 0;
    stallIn_n <= stall_cmd == 0;
  end
endmodule

// ===== sim/programmed_io_party_line_bus_tb.sv
module programmed_io_party_line_bus_tb
  import iob_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst_n, cmdValid, cmdReady, loadReq, loadActive_n, rdy;
  logic resValid, resReady, resSkip, resLoad, busy, ioDataOe, stallGo;
  logic outXferInd_n, inXferInd_n, ctrlPulseInd_n, skipTestInd_n, maskQ;
  logic setMaskInd_n, xferStrobe_n, readyTest_n, stallIn_n, intReq_n;
  logic [2:0] cmdOp;
  logic [5:0] cmdAddr, ioAddr_n;
  logic [11:0] cmdAcc, resData, ioDataOut_n, busData_n, drvData_n;
  logic [11:0] rdData, gotData;
  logic [11:0] accQ[$]; // Words queued while nothing drains
  int ctrlCnt, error_cnt, samples_checked, seed, n;

  always #10 ref_clk = ~ref_clk;
  // Wired bus: any party pulling low wins
  assign busData_n = (ioDataOe ? ioDataOut_n : 12'hfff) & drvData_n;

  iob_bus_ctrl iob_bus_ctrl_i (.ref_clk, .rst_n, .cmdValid, .cmdReady, .cmdOp,
    .cmdAddr, .cmdAcc, .loadReq, .loadActive_n, .resValid, .resReady, .resData,
    .resSkip, .resLoad, .busy, .ioDataIn_n(busData_n), .ioDataOut_n, .ioDataOe,
    .ioAddr_n, .outXferInd_n, .inXferInd_n, .ctrlPulseInd_n, .skipTestInd_n,
    .setMaskInd_n, .xferStrobe_n, .readyTest_n, .stallIn_n);
  iob_periph_model iob_periph_model_i (.ref_clk, .rst_n, .rdy, .rdData,
    .stallGo, .ioAddr_n, .busData_n, .outXferInd_n, .inXferInd_n,
    .skipTestInd_n, .ctrlPulseInd_n, .setMaskInd_n, .xferStrobe_n,
    .loadActive_n, .drvData_n, .readyTest_n, .stallIn_n, .gotData, .maskQ,
    .ctrlCnt, .intReq_n);

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic bound(input int k, input int lim);
    if (k >= lim) begin
      error_cnt++;
      results();
    end
  endtask
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask
  task automatic waitRes();
    int k = 0;
    while (resValid !== 1'b1 && k < 600) begin
      tick();
      k++;
    end
    bound(k, 600);
  endtask
  // Take one word after a random stall of the reader
  task automatic pop();
    repeat (2'($random(seed))) tick();
    resReady = 1'b1;
    tick();
    resReady = 1'b0;
  endtask
  // Expected {load, skip, data}
  function automatic logic [13:0] expRes(input logic [2:0] op,
      input logic r, input logic [11:0] acc, input logic [11:0] rd);
    case (op)
      3'h1, 3'h3: return {1'b0, r, acc};
      3'h2: return {1'b0, r, r ? rd : 12'h000};
      default: return {2'b00, acc};
    endcase
  endfunction
  // One command, result and side effects checked
  task automatic run(input logic [2:0] op, input logic [5:0] a, input logic r);
    logic [11:0] acc = 12'($random(seed));
    logic [11:0] g0 = gotData;
    logic me = a == 6'h01;
    int c0 = ctrlCnt;
    int k = 0;
    rdData = 12'($random(seed));
    rdy = r;
    cmdOp = op;
    cmdAddr = a;
    cmdAcc = acc;
    cmdValid = 1'b1;
    while (cmdReady !== 1'b1 && k < 400) begin
      tick();
      k++;
    end
    bound(k, 400);
    tick();
    cmdValid = 1'b0;
    if (op == 3'h5) begin
      repeat (40) tick();
      chk(busy, 1'b1);
      stallGo = 1'b1;
      tick();
      stallGo = 1'b0;
      // Let the pulse die out so a following stall really waits
      repeat (34) tick();
    end
    waitRes();
    chk({resLoad, resSkip, resData}, expRes(op, r && me, acc, rdData));
    chk(gotData, op == 3'h1 && r && me ? acc : g0);
    if (op == 3'h0) chk(ctrlCnt != c0, me);
    if (op == 3'h4 && !a[0]) chk(maskQ, acc[3]);
    pop();
  endtask

  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    {cmdValid, loadReq, resReady, rdy, stallGo} = 5'h00;
    cmdOp = 3'h0;
    cmdAddr = 6'h00;
    cmdAcc = 12'h000;
    rdData = 12'h000;
    error_cnt = 0;
    samples_checked = 0;
    seed = 32'h87ec671a;
    repeat (16) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    // Every code, ready then not, back to back
    for (int i = 0; i < 12; i++) run(3'(i / 2), 6'h01, i % 2 == 0);
    run(3'h2, 6'h2a, 1'b1);
    run(3'h4, 6'h00, 1'b1);
    chk(intReq_n, !maskQ);
    for (int i = 0; i < 10; i++) begin
      n = $random(seed);
      run(3'($unsigned(n) % 6), n[8] ? 6'h01 : n[14:9], n[20]);
    end
    // Hardware load cycle
    rdy = 1'b1;
    rdData = 12'($random(seed));
    loadReq = 1'b1;
    n = 0;
    while (busy !== 1'b1 && n < 50) begin
      tick();
      n++;
    end
    bound(n, 50);
    loadReq = 1'b0;
    waitRes();
    chk({resLoad, resData}, {1'b1, rdData});
    pop();
    // Fill the buffer with quick codes until refused
    cmdOp = 3'h6;
    cmdValid = 1'b1;
    for (int i = 0; i < 200; i++) begin
      if (cmdReady === 1'b1) begin
        accQ.push_back(cmdAcc);
        tick();
        cmdAcc = 12'($random(seed));
      end else tick();
    end
    cmdValid = 1'b0;
    chk(16'(accQ.size()), 16'h0010);
    while (accQ.size() > 0) begin
      waitRes();
      chk({resLoad, resSkip, resData}, {2'b00, accQ.pop_front()});
      pop();
    end
    chk(resValid, 1'b0);
    results();
  end
endmodule

bind iob_bus_ctrl iob_bus_ctrl_checker #(.DataW(DataW)) iob_bus_ctrl_checker_i (
  .ref_clk, .rst_n, .cmdValid, .cmdReady, .cmdOp, .cmdAddr, .cmdAcc, .loadReq,
  .busy, .ioDataOut_n, .ioDataOe, .ioAddr_n, .outXferInd_n, .inXferInd_n,
  .skipTestInd_n, .xferStrobe_n, .readyTest_n, .stallIn_n);
